// ==== seu_event_status.sv ====
/*
 * Standard event status unit: event latch, enable mask, summary bit,
 * error queue and clear-status handling. Assumes a command decoder that
 * issues one-cycle strobes synchronous to clk.
 */
`timescale 1ns/100ps

// How it works
// - The enable mask holds 0 to 255, the controller writes only that range, and it resets to 0.
// - A mask bit of 1 lets its event reach the summary and a 0 blocks it.
// - The summary is the OR of masked event bits and drives status byte bit 5.
// - A mask query returns the stored mask with the event bit weights.
// - An event query returns the whole latch and then clears it.
// - Command, execution, device, query error and operation complete sit at bits 5,4,3,2,0.
// - A 100-series error sets the command error bit.
// - A 200-series error sets the execution error bit.
// - A 300-series error sets the device error bit.
// - A readback error with its questionable bit set also sets the device error bit.
// - A 400-series error sets the query error bit.
// - Clear-status empties the error queue.
// - Clear-status returns operation-complete tracking to idle.
// - Clear-status clears event registers and status byte but keeps all masks.
// - Operation complete is set only after earlier work ends, without stalling later commands.
module seu_event_status #(
	parameter int QDEPTH = seu_pkg::ERRQ_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic mask_wr,
	input wire logic [7:0] mask_wdata,
	input wire logic mask_rd,
	input wire logic latch_rd,
	input wire logic clear_status,
	input wire logic err_valid,
	input wire logic [seu_pkg::ERRQ_CODE_W-1:0] err_code,
	input wire logic readback_err,
	input wire logic questionable_set,
	input wire logic opc_cmd,
	input wire logic ops_pending,
	input wire logic oper_event,
	input wire logic ques_event,
	input wire logic errq_pop,
	output logic [7:0] rdata,
	output logic rvalid,
	output logic [7:0] status_byte_reg,
	output logic event_summary_bit,
	output logic [seu_pkg::ERRQ_CODE_W-1:0] errq_head,
	output logic errq_empty,
	output logic oper_event_q,
	output logic ques_event_q
);
	localparam int PW = $clog2(QDEPTH);

	// ------------------------------------------------------------
	// Error classification
	// ------------------------------------------------------------
	logic [2:0] err_class;
	logic [7:0] set_vec;
	logic opc_done;

	always_comb begin
		err_class = 3'h0;
		if (err_code >= 10'h064 && err_code < 10'h1F4) begin
			err_class = 3'(err_code / 10'h064);
		end
		set_vec = 8'h00;
		if (err_valid) begin
			set_vec[seu_pkg::BIT_CME] = (err_class == seu_pkg::CLASS_CMD);
			set_vec[seu_pkg::BIT_EXE] = (err_class == seu_pkg::CLASS_EXE);
			set_vec[seu_pkg::BIT_DDE] = (err_class == seu_pkg::CLASS_DEV);
			set_vec[seu_pkg::BIT_QUE] = (err_class == seu_pkg::CLASS_QRY);
		end
		if (readback_err && questionable_set) begin
			set_vec[seu_pkg::BIT_DDE] = 1'b1;
		end
		set_vec[seu_pkg::BIT_OPC] = opc_done;
	end

	// ------------------------------------------------------------
	// Operation-complete tracking
	// ------------------------------------------------------------
	seu_opc_tracker u_opc (
		.clk(clk),
		.rst_n(rst_n),
		.opc_cmd(opc_cmd),
		.ops_pending(ops_pending),
		.clear_status(clear_status),
		.opc_done(opc_done)
	);

	// ------------------------------------------------------------
	// Mask, summary and status byte
	// ------------------------------------------------------------
	logic [7:0] mask_q, mask_d;
	logic [7:0] latch_q, latch_d;
	logic summary_d;
	logic [7:0] stb_d;
	logic oper_d, ques_d;

	always_comb begin
		mask_d = mask_q;
		if (mask_wr) begin
			mask_d = mask_wdata;
		end
		summary_d = |(latch_d & mask_d);
		stb_d = 8'h00;
		stb_d[seu_pkg::STB_SUMMARY_BIT] = summary_d;
		oper_d = (oper_event_q && !clear_status) || oper_event;
		ques_d = (ques_event_q && !clear_status) || ques_event;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= seu_pkg::MASK_RESET;
			latch_q <= seu_pkg::LATCH_RESET;
			event_summary_bit <= 1'b0;
			status_byte_reg <= 8'h00;
			oper_event_q <= 1'b0;
			ques_event_q <= 1'b0;
		end else begin
			mask_q <= mask_d;
			latch_q <= latch_d;
			event_summary_bit <= summary_d;
			status_byte_reg <= stb_d;
			oper_event_q <= oper_d;
			ques_event_q <= ques_d;
		end
	end

	// ------------------------------------------------------------
	// Event latch, one sticky slice per bit
	// ------------------------------------------------------------
	logic latch_wipe;

	assign latch_wipe = latch_rd || clear_status;

	for (genvar gi = 0; gi < seu_pkg::EVT_W; gi++) begin : g_latch
		// Set wins over a simultaneous read or clear
		assign latch_d[gi] = set_vec[gi] | (latch_wipe ? seu_pkg::LATCH_RESET[gi] : latch_q[gi]);
	end

	// ------------------------------------------------------------
	// Query answer
	// ------------------------------------------------------------
	logic [7:0] rdata_d;
	logic rvalid_d;

	always_comb begin
		rdata_d = rdata;
		rvalid_d = 1'b0;
		if (latch_rd) begin
			rdata_d = latch_q;
			rvalid_d = 1'b1;
		end else if (mask_rd) begin
			rdata_d = mask_q;
			rvalid_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
			rvalid <= 1'b0;
		end else begin
			rdata <= rdata_d;
			rvalid <= rvalid_d;
		end
	end

	// ------------------------------------------------------------
	// Error queue
	// ------------------------------------------------------------
	logic [seu_pkg::ERRQ_CODE_W-1:0] q_mem [QDEPTH];
	logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [PW:0] cnt_q, cnt_d;
	logic push, pop;
	logic [seu_pkg::ERRQ_CODE_W-1:0] head_d;
	logic empty_d;

	always_comb begin
		push = err_valid && (cnt_q != (PW+1)'(QDEPTH)) && !clear_status;
		pop = errq_pop && (cnt_q != '0) && !clear_status;
		wp_d = wp_q;
		rp_d = rp_q;
		cnt_d = cnt_q;
		if (clear_status) begin
			wp_d = '0;
			rp_d = '0;
			cnt_d = '0;
		end else begin
			if (push) begin
				wp_d = (wp_q == PW'(QDEPTH-1)) ? '0 : wp_q + 1'b1;
			end
			if (pop) begin
				rp_d = (rp_q == PW'(QDEPTH-1)) ? '0 : rp_q + 1'b1;
			end
			cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
		end
		empty_d = (cnt_d == '0);
		head_d = '0;
		if (!empty_d) begin
			if (push && rp_d == wp_q) begin
				// Entry is being written this cycle: bypass the array
				head_d = err_code;
			end else begin
				head_d = q_mem[rp_d];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			q_mem[wp_q] <= err_code;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			errq_head <= '0;
			errq_empty <= 1'b1;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
			errq_head <= head_d;
			errq_empty <= empty_d;
		end
	end
endmodule : seu_event_status

// ==== seu_pkg.sv ====
/*
 * Constants for the standard event status unit: bit positions, error
 * classes, reset values. Assumes nothing of its surroundings.
 */
package seu_pkg;
	localparam int EVT_W = 8;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam int BIT_OPC = 0;
	localparam int BIT_QUE = 2;
	localparam int BIT_DDE = 3;
	localparam int BIT_EXE = 4;
	localparam int BIT_CME = 5;
	localparam int STB_SUMMARY_BIT = 5;
	// Error class = hundreds digit of the error code
	localparam logic [2:0] CLASS_CMD = 3'h1;
	localparam logic [2:0] CLASS_EXE = 3'h2;
	localparam logic [2:0] CLASS_DEV = 3'h3;
	localparam logic [2:0] CLASS_QRY = 3'h4;
	localparam int ERRQ_DEPTH = 8;
	localparam int ERRQ_CODE_W = 10;
endpackage : seu_pkg

// ==== seu_opc_tracker.sv ====
/*
 * Operation-complete tracker: arms on the operation-complete command and
 * fires once nothing is pending. Assumes a pending level from the executor.
 */
`timescale 1ns/100ps
module seu_opc_tracker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic opc_cmd,
	input wire logic ops_pending,
	input wire logic clear_status,
	output logic opc_done
);
	typedef enum logic {SEU_OPC_IDLE, SEU_OPC_WAIT} seu_opc_state_t;
	seu_opc_state_t state_q, state_d;
	logic done_d;

	always_comb begin
		state_d = state_q;
		done_d = 1'b0;
		unique case (state_q)
			SEU_OPC_IDLE: begin
				if (opc_cmd) begin
					state_d = SEU_OPC_WAIT;
				end
			end
			SEU_OPC_WAIT: begin
				if (!ops_pending) begin
					done_d = 1'b1;
					state_d = SEU_OPC_IDLE;
				end
			end
		endcase
		if (clear_status) begin
			state_d = SEU_OPC_IDLE;
			done_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SEU_OPC_IDLE;
			opc_done <= 1'b0;
		end else begin
			state_q <= state_d;
			opc_done <= done_d;
		end
	end
endmodule : seu_opc_tracker

// ==== seu_event_status_sva.sv ====
/*
 * Port assertions for the event status unit, with one helper register.
 * Assumes it is bound into every instance and sees only its ports.
 */
`timescale 1ns/100ps
module seu_event_status_sva (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic mask_wr,
	input wire logic mask_rd,
	input wire logic latch_rd,
	input wire logic clear_status,
	input wire logic err_valid,
	input wire logic oper_event,
	input wire logic ques_event,
	input wire logic rvalid,
	input wire logic event_summary_bit,
	input wire logic errq_empty,
	input wire logic oper_event_q,
	input wire logic ques_event_q,
	input wire logic [7:0] mask_wdata,
	input wire logic [7:0] rdata,
	input wire logic [7:0] status_byte_reg,
	input wire logic [9:0] errq_head
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Last mask written by the controller, zero after reset
	logic [7:0] mask_seen_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_seen_q <= 8'h00;
		end else if (mask_wr) begin
			mask_seen_q <= mask_wdata;
		end
	end

	query_answer_a: assert property (latch_rd || mask_rd |=> rvalid)
		else $error("query not answered");
	stray_ans_a: assert property (rvalid |-> $past(latch_rd || mask_rd))
		else $error("answer without query");
	mask_back_a: assert property (
		mask_rd && !latch_rd && !mask_wr |=> rdata == mask_seen_q)
		else $error("mask readback wrong");
	stb_bit_a: assert property (status_byte_reg == {2'h0, event_summary_bit, 5'h00})
		else $error("status byte wrong");
	sum_stick_a: assert property (
		event_summary_bit && !latch_rd && !clear_status && !mask_wr |=> event_summary_bit)
		else $error("summary dropped");
	clear_all_a: assert property (
		clear_status && !err_valid && !oper_event && !ques_event
		|=> errq_empty && !oper_event_q && !ques_event_q)
		else $error("clear incomplete");
	head_zero_a: assert property (errq_empty |-> errq_head == 10'h000)
		else $error("empty queue head");
	push_seen_a: assert property (err_valid && !clear_status |=> !errq_empty)
		else $error("error not queued");
endmodule : seu_event_status_sva
bind seu_event_status seu_event_status_sva chk (
	.clk(clk),
	.rst_n(rst_n),
	.mask_wr(mask_wr),
	.mask_rd(mask_rd),
	.latch_rd(latch_rd),
	.clear_status(clear_status),
	.err_valid(err_valid),
	.oper_event(oper_event),
	.ques_event(ques_event),
	.rvalid(rvalid),
	.event_summary_bit(event_summary_bit),
	.errq_empty(errq_empty),
	.oper_event_q(oper_event_q),
	.ques_event_q(ques_event_q),
	.mask_wdata(mask_wdata),
	.rdata(rdata),
	.status_byte_reg(status_byte_reg),
	.errq_head(errq_head)
);

// ==== seu_ctl_model.sv ====
/* Remote controller model issuing command strobes. Assumes clk from the bench. */
`timescale 1ns/100ps
module seu_ctl_model (
	input wire logic clk,
	output logic [5:0] s,
	output logic [9:0] v
);
	initial s = 6'h00;
	initial v = 10'h000;
	// One-cycle strobe, data inverted once released
	task automatic issue(input int op, input logic [9:0] d);
		@(posedge clk) #1;
		s = 6'h01 << op;
		v = d;
		@(posedge clk) #1;
		s = 6'h00;
		v = ~v;
	endtask : issue
endmodule : seu_ctl_model

// ==== tb.sv ====
/* Self-checking bench for the event status unit. Assumes the controller model. */
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
$display("ERROR %s exp %h got %h", n, e, g); end end
module tb;
	logic clk = 1'b0, rst_n = 1'b0, rb = 1'b0, qs = 1'b0, pd = 1'b0, oe = 1'b0, pop = 1'b0;
	logic rv, sum, emp, oq, qq;
	logic [5:0] s;
	logic [9:0] v, head;
	logic [7:0] rd, sb;
	int n_errors = 0;
	int check_count = 0;
	always #2 clk = ~clk;
	seu_ctl_model ctl (.clk(clk), .s(s), .v(v));
	seu_event_status uut (.clk(clk), .rst_n(rst_n), .mask_wr(s[0]), .mask_wdata(v[7:0]),
		.mask_rd(s[1]), .latch_rd(s[2]), .clear_status(s[3]), .err_valid(s[4]), .err_code(v),
		.readback_err(rb), .questionable_set(qs), .opc_cmd(s[5]), .ops_pending(pd),
		.oper_event(oe), .ques_event(oe), .errq_pop(pop), .rdata(rd), .rvalid(rv),
		.status_byte_reg(sb), .event_summary_bit(sum), .errq_head(head), .errq_empty(emp),
		.oper_event_q(oq), .ques_event_q(qq));
	task automatic results;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results
	task automatic rdl(input logic [7:0] e);
		ctl.issue(2, 10'h000);
		`CHK("latch", {1'b1, e}, {rv, rd})
	endtask : rdl
	task automatic t_mask;
		ctl.issue(1, 10'h000);
		`CHK("mask0", 9'h100, {rv, rd})
		ctl.issue(0, 10'h0FF);
		ctl.issue(1, 10'h000);
		`CHK("mask", 9'h1FF, {rv, rd})
	endtask : t_mask
	task automatic t_class;
		ctl.issue(0, 10'h03C);
		for (int i = 1; i < 6; i++) begin
			ctl.issue(4, 10'(i * 100 + 50));
			`CHK("sum", {i < 5, 8'(i < 5) << 5}, {sum, sb})
			rdl(i < 5 ? 8'h40 >> i : 8'h00);
			rdl(8'h00);
		end
	endtask : t_class
	task automatic t_block;
		ctl.issue(0, 10'h020);
		ctl.issue(4, 10'h0FA);
		`CHK("blocked", 1'b0, sum)
		ctl.issue(0, 10'h010);
		@(posedge clk) #1;
		`CHK("passed", 9'h120, {sum, sb})
		ctl.issue(4, 10'h12B);
		rdl(8'h10);
	endtask : t_block
	task automatic t_clear;
		ctl.issue(3, 10'h000);
		ctl.issue(4, 10'h065);
		ctl.issue(4, 10'h1F3);
		`CHK("head", 10'h065, head)
		pop = 1'b1;
		{rb, qs, oe} = 3'h7;
		@(posedge clk) #1 {pop, rb, qs, oe} = 4'h0;
		`CHK("pop", 10'h1F3, head)
		rdl(8'h2C);
		ctl.issue(3, 10'h000);
		`CHK("cleared", 3'b100, {emp, oq, qq})
		ctl.issue(1, 10'h000);
		`CHK("kept", 9'h110, {rv, rd})
	endtask : t_clear
	task automatic t_opc;
		ctl.issue(0, 10'h001);
		pd = 1'b1;
		ctl.issue(5, 10'h000);
		ctl.issue(4, 10'h078);
		repeat (4) @(posedge clk);
		#1 `CHK("early", 1'b0, sum)
		pd = 1'b0;
		repeat (4) @(posedge clk);
		#1 rdl(8'h21);
		pd = 1'b1;
		ctl.issue(5, 10'h000);
		ctl.issue(3, 10'h000);
		pd = 1'b0;
		repeat (4) @(posedge clk);
		#1 rdl(8'h00);
	endtask : t_opc
	initial begin
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		t_mask;
		t_class;
		t_block;
		t_clear;
		t_opc;
		results;
	end
	initial begin
		#20000;
		n_errors++;
		results;
	end
endmodule : tb
